/* common/pcr_pkg.sv */
// Purpose: Shared constants and types for the processor control-register bank
// Assumes: Register selects are the architectural control-register numbers
// Notes: Reset values follow a processor power-up state with paging off
package pcr_pkg;

  // Register selects (control-register numbers)
  localparam logic [3:0] SEL_SYSTEM_CONTROL = 4'h0;
  localparam logic [3:0] SEL_RESERVED_CONTROL = 4'h1;
  localparam logic [3:0] SEL_FAULT_LINEAR_ADDRESS = 4'h2;
  localparam logic [3:0] SEL_TABLE_BASE = 4'h3;
  localparam logic [3:0] SEL_EXTENSION_CONTROL = 4'h4;
  localparam logic [3:0] SEL_PRIORITY_THRESHOLD = 4'h8;

  // System control bit positions
  localparam int BIT_PROTECTION_ON = 0;
  localparam int BIT_WAIT_MONITOR = 1;
  localparam int BIT_FPU_EMULATION = 2;
  localparam int BIT_CONTEXT_SWITCHED = 3;
  localparam int BIT_COPROCESSOR_TYPE = 4;
  localparam int BIT_NATIVE_ERROR_REPORT = 5;
  localparam int BIT_WRITE_GUARD = 16;
  localparam int BIT_ALIGN_CHECK_MASK = 18;
  localparam int BIT_NO_WRITETHROUGH = 29;
  localparam int BIT_CACHE_OFF = 30;
  localparam int BIT_PAGING_ON = 31;

  // Table base bit positions
  localparam int BIT_DIR_WRITE_THROUGH = 3;
  localparam int BIT_DIR_CACHE_OFF = 4;
  localparam int DIR_ALIGN_BITS = 12;

  // Writable masks
  localparam logic [63:0] SYSTEM_CONTROL_MASK = 64'h0000_0000_e005_002f;
  localparam logic [63:0] PRIORITY_MASK = 64'h0000_0000_0000_000f;
  localparam logic [63:0] UPPER_HALF_MASK = 64'hffff_ffff_0000_0000;

  // Reset values
  localparam logic [63:0] SYSTEM_CONTROL_RESET = 64'h0000_0000_6000_0010;
  localparam logic [63:0] ZERO_RESET = 64'h0000_0000_0000_0000;
  localparam logic [63:0] COPROC_TYPE_ONE = 64'h0000_0000_0000_0010;

  localparam logic [1:0] PRIV_KERNEL = 2'h0;
  localparam logic [1:0] PRIV_USER = 2'h3;
  localparam logic [15:0] FAULT_CODE_ZERO = 16'h0000;

  // Processor execution context
  typedef struct packed {
    logic long_mode;
    logic protected_mode;
    logic v86_mode;
    logic [1:0] current_privilege;
    logic align_check_flag;
  } pcr_mode_t;

  // Move request
  typedef struct packed {
    logic valid;
    logic write;
    logic [3:0] sel;
    logic [63:0] data;
  } pcr_move_t;

  // Move answer
  typedef struct packed {
    logic done;
    logic protection_fault;
    logic [15:0] fault_code;
    logic [63:0] data;
  } pcr_answer_t;

  // Instruction to classify
  typedef struct packed {
    logic valid;
    logic is_fpu;
    logic is_vector;
    logic is_wait;
    logic is_exempt;
  } pcr_instr_t;

  // Control flags exported to the core
  typedef struct packed {
    logic paging_on;
    logic cache_all;
    logic write_back_hits;
    logic align_check_active;
    logic write_guard;
    logic dir_cache_off;
    logic dir_write_through;
    logic [51:0] directory_base_pointer;
    logic [3:0] task_priority_level;
  } pcr_flags_t;

endpackage

/* design/pcr_bank.sv */
// Purpose: Processor control-register bank with move checks and instruction gating
// Assumes: One move request per cycle; answer is registered one cycle later
// Notes: Single clock domain; ignore_error_in is a pin and is synchronised
`timescale 1ns/1ps

//
// Contract
// R01: Nonzero upper half write faults, code zero
// R02: Fault address fully writable in long mode
// R03: Software keeps table base 51:40 zero
// R04: No address limit checks on writes
// R05: Priority register only reachable in long mode
// R06: Directory base low twelve bits zero
// R07: Directory flags affect data cache only
// R08: Protected-mode moves only at privilege zero
// R09: Paging flag enables translation
// R10: Paging without protection faults
// R11: Both cache flags clear caches everything
// R12: Alignment check needs four conditions
// R13: Write guard blocks supervisor read-only writes
// R14: Native error flag selects internal reporting
// R15: Legacy mode with ignore input drops errors
// R16: Legacy unmasked error drives error pin
// R17: Coprocessor type reads one, fixed
// R18: Task switch sets context-switched flag
// R19: Switched, no emulation faults fpu/vector
// R20: Wait executes without monitor or emulation
// R21: Emulation overrides context-switched flag
// R22: Handler clears switched flag, no save
// R23: Emulation faults every floating-point instruction
// R24: Monitor plus switched faults wait
module pcr_bank (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire pcr_pkg::pcr_mode_t i_mode,
  input wire pcr_pkg::pcr_move_t i_move,
  input wire logic i_task_switch,
  input wire logic i_clear_switched_instr,
  input wire pcr_pkg::pcr_instr_t i_instr,
  input wire logic i_fpu_error,
  input wire logic i_ignore_error_in_n,
  output pcr_pkg::pcr_answer_t o_answer,
  output logic o_device_unavailable_fault,
  output logic o_fpu_internal_fault,
  output logic o_fpu_error_out_n,
  output logic o_fpu_stall,
  output pcr_pkg::pcr_flags_t o_flags
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser
  logic ign_meta;
  logic ign_sync;

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      ign_meta <= 1'b0;
      ign_sync <= 1'b0;
    end
    else
    begin
      ign_meta <= ~i_ignore_error_in_n;
      ign_sync <= ign_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [63:0] system_control;
  logic [63:0] fault_linear_address;
  logic [63:0] table_base;
  logic [63:0] extension_control;
  logic [63:0] priority_threshold;
  logic [63:0] next_system_control;
  logic [63:0] next_fault_linear_address;
  logic [63:0] next_table_base;
  logic [63:0] next_extension_control;
  logic [63:0] next_priority_threshold;
  pcr_pkg::pcr_answer_t next_answer;
  logic refuse;
  logic wr;

  always_comb
  begin
    next_system_control = system_control;
    next_fault_linear_address = fault_linear_address;
    next_table_base = table_base;
    next_extension_control = extension_control;
    next_priority_threshold = priority_threshold;
    next_answer = '0;
    refuse = 1'b0;
    if (i_move.valid)
    begin
      if (i_mode.protected_mode && i_mode.current_privilege != pcr_pkg::PRIV_KERNEL)
        refuse = 1'b1; // R08
      if (i_move.sel == pcr_pkg::SEL_RESERVED_CONTROL)
        refuse = 1'b1;
      if (i_move.sel == pcr_pkg::SEL_PRIORITY_THRESHOLD && !i_mode.long_mode)
        refuse = 1'b1; // R05
      if (i_move.sel != pcr_pkg::SEL_SYSTEM_CONTROL && i_move.sel != pcr_pkg::SEL_TABLE_BASE &&
          i_move.sel != pcr_pkg::SEL_FAULT_LINEAR_ADDRESS &&
          i_move.sel != pcr_pkg::SEL_EXTENSION_CONTROL &&
          i_move.sel != pcr_pkg::SEL_PRIORITY_THRESHOLD)
        refuse = 1'b1;
      if (i_move.write && i_mode.long_mode &&
          (i_move.sel == pcr_pkg::SEL_SYSTEM_CONTROL ||
           i_move.sel == pcr_pkg::SEL_EXTENSION_CONTROL) &&
          (i_move.data & pcr_pkg::UPPER_HALF_MASK) != pcr_pkg::ZERO_RESET)
        refuse = 1'b1; // R01
      if (i_move.write && i_move.sel == pcr_pkg::SEL_SYSTEM_CONTROL &&
          i_move.data[pcr_pkg::BIT_PAGING_ON] && !i_move.data[pcr_pkg::BIT_PROTECTION_ON])
        refuse = 1'b1; // R10
      next_answer.done = 1'b1;
      next_answer.protection_fault = refuse;
      next_answer.fault_code = pcr_pkg::FAULT_CODE_ZERO; // R01
    end
    wr = i_move.valid && i_move.write && !refuse;
    if (wr)
    begin
      unique case (i_move.sel)
        pcr_pkg::SEL_SYSTEM_CONTROL:
          next_system_control = (i_move.data & pcr_pkg::SYSTEM_CONTROL_MASK) |
                                pcr_pkg::COPROC_TYPE_ONE; // R17
        pcr_pkg::SEL_FAULT_LINEAR_ADDRESS:
          // Whole word stored in long mode (upper half cleared outside it), no limit check
          next_fault_linear_address = i_move.data; // R02 R04
        pcr_pkg::SEL_TABLE_BASE:
          next_table_base = i_move.data; // R04
        pcr_pkg::SEL_EXTENSION_CONTROL:
          next_extension_control = i_move.data & ~pcr_pkg::UPPER_HALF_MASK;
        default:
          next_priority_threshold = i_move.data & pcr_pkg::PRIORITY_MASK;
      endcase
    end
    if (!i_mode.long_mode)
    begin
      next_fault_linear_address[63:32] = 32'h0000_0000;
      if (wr && i_move.sel == pcr_pkg::SEL_TABLE_BASE)
        next_table_base[63:32] = 32'h0000_0000;
    end
    // Set wins over clear
    if (i_clear_switched_instr)
      next_system_control[pcr_pkg::BIT_CONTEXT_SWITCHED] = 1'b0; // R22
    if (i_task_switch)
      next_system_control[pcr_pkg::BIT_CONTEXT_SWITCHED] = 1'b1; // R18
    if (i_move.valid && !i_move.write && !refuse)
    begin
      unique case (i_move.sel)
        pcr_pkg::SEL_SYSTEM_CONTROL: next_answer.data = system_control;
        pcr_pkg::SEL_FAULT_LINEAR_ADDRESS: next_answer.data = fault_linear_address;
        pcr_pkg::SEL_TABLE_BASE: next_answer.data = table_base;
        pcr_pkg::SEL_EXTENSION_CONTROL: next_answer.data = extension_control;
        default: next_answer.data = priority_threshold;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      system_control <= pcr_pkg::SYSTEM_CONTROL_RESET;
      fault_linear_address <= pcr_pkg::ZERO_RESET;
      table_base <= pcr_pkg::ZERO_RESET;
      extension_control <= pcr_pkg::ZERO_RESET;
      priority_threshold <= pcr_pkg::ZERO_RESET;
      o_answer <= '0;
    end
    else
    begin
      system_control <= next_system_control;
      fault_linear_address <= next_fault_linear_address;
      table_base <= next_table_base;
      extension_control <= next_extension_control;
      priority_threshold <= next_priority_threshold;
      o_answer <= next_answer;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flag decode
  logic paging_flag;
  logic protect_flag;
  logic cache_off_flag;
  logic no_wt_flag;
  logic switched_flag;
  logic emulate_flag;
  logic monitor_flag;
  logic native_flag;

  assign paging_flag = system_control[pcr_pkg::BIT_PAGING_ON];
  assign protect_flag = system_control[pcr_pkg::BIT_PROTECTION_ON];
  assign cache_off_flag = system_control[pcr_pkg::BIT_CACHE_OFF];
  assign no_wt_flag = system_control[pcr_pkg::BIT_NO_WRITETHROUGH];
  assign switched_flag = system_control[pcr_pkg::BIT_CONTEXT_SWITCHED];
  assign emulate_flag = system_control[pcr_pkg::BIT_FPU_EMULATION];
  assign monitor_flag = system_control[pcr_pkg::BIT_WAIT_MONITOR];
  assign native_flag = system_control[pcr_pkg::BIT_NATIVE_ERROR_REPORT];

  always_comb
  begin
    o_flags.paging_on = paging_flag && protect_flag; // R09
    o_flags.cache_all = !cache_off_flag && !no_wt_flag; // R11
    o_flags.write_back_hits = !cache_off_flag && !no_wt_flag; // R11
    o_flags.align_check_active = system_control[pcr_pkg::BIT_ALIGN_CHECK_MASK] &&
        i_mode.align_check_flag && i_mode.current_privilege == pcr_pkg::PRIV_USER &&
        (i_mode.protected_mode || i_mode.v86_mode); // R12
    o_flags.write_guard = system_control[pcr_pkg::BIT_WRITE_GUARD]; // R13
    // Directory caching flags only meaningful for the data cache, with paging on
    o_flags.dir_cache_off = table_base[pcr_pkg::BIT_DIR_CACHE_OFF] &&
        paging_flag && !cache_off_flag; // R07
    o_flags.dir_write_through = table_base[pcr_pkg::BIT_DIR_WRITE_THROUGH] &&
        paging_flag && !cache_off_flag; // R07
    // Physical base is 52 bits, low page-offset bits forced clear
    o_flags.directory_base_pointer = {table_base[51:pcr_pkg::DIR_ALIGN_BITS],
                                      12'h000}; // R06
    // Filtering level stays in force outside long mode
    o_flags.task_priority_level = priority_threshold[3:0]; // R05
  end

  ////////////////////////////////////////////////////////////////////////////
  // Instruction gating
  always_comb
  begin
    o_device_unavailable_fault = 1'b0;
    if (i_instr.valid)
    begin
      if (i_instr.is_wait)
        o_device_unavailable_fault = monitor_flag && switched_flag; // R20 R24
      else if (i_instr.is_fpu && emulate_flag)
        o_device_unavailable_fault = 1'b1; // R21 R23
      else if ((i_instr.is_fpu || i_instr.is_vector) && !i_instr.is_exempt && !emulate_flag)
        o_device_unavailable_fault = switched_flag; // R18 R19
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Floating-point error reporting
  logic err_pending;
  logic next_err_pending;
  logic next_internal;

  always_comb
  begin
    next_err_pending = err_pending;
    next_internal = 1'b0;
    if (i_fpu_error)
    begin
      if (native_flag)
        next_internal = 1'b1; // R14
      else if (!ign_sync)
        next_err_pending = 1'b1; // R16
    end
    if (native_flag || ign_sync)
      next_err_pending = 1'b0; // R15
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      err_pending <= 1'b0;
      o_fpu_internal_fault <= 1'b0;
    end
    else
    begin
      err_pending <= next_err_pending;
      o_fpu_internal_fault <= next_internal;
    end
  end

  assign o_fpu_error_out_n = ~err_pending; // R16
  assign o_fpu_stall = err_pending && i_instr.valid && (i_instr.is_fpu || i_instr.is_wait);

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  upper_half_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R01
    i_move.valid && i_move.write && i_mode.long_mode &&
    i_move.sel == pcr_pkg::SEL_SYSTEM_CONTROL && i_move.data[63:32] != 32'h0
    |=> o_answer.protection_fault && o_answer.fault_code == 16'h0000)
    else $error("upper half write not refused");
  ext_upper_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R01
    i_move.valid && i_move.write && i_mode.long_mode &&
    i_move.sel == pcr_pkg::SEL_EXTENSION_CONTROL && i_move.data[63:32] != 32'h0
    |=> o_answer.protection_fault && $stable(extension_control))
    else $error("extension upper half write not refused");
  priv_refuse_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R08
    i_move.valid && i_mode.protected_mode && i_mode.current_privilege != 2'h0
    |=> o_answer.done && o_answer.protection_fault)
    else $error("nonzero privilege move accepted");
  priv_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R08
    i_move.valid && i_move.write && i_mode.protected_mode &&
    i_mode.current_privilege != 2'h0
    |=> $stable(table_base) && $stable(extension_control) && $stable(priority_threshold))
    else $error("nonzero privilege write landed");
  long_only_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R05
    i_move.valid && i_move.sel == pcr_pkg::SEL_PRIORITY_THRESHOLD && !i_mode.long_mode
    |=> o_answer.protection_fault)
    else $error("priority register reached outside long mode");
  fault_addr_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R02
    i_move.valid && i_move.write && i_mode.long_mode && !i_task_switch &&
    i_move.sel == pcr_pkg::SEL_FAULT_LINEAR_ADDRESS && !refuse
    |=> fault_linear_address == $past(i_move.data))
    else $error("fault address not stored");
  table_store_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R04
    i_move.valid && i_move.write && i_mode.long_mode &&
    i_move.sel == pcr_pkg::SEL_TABLE_BASE && !refuse
    |=> table_base == $past(i_move.data))
    else $error("table base not stored");
  paging_prot_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R10
    i_move.valid && i_move.write && i_move.sel == pcr_pkg::SEL_SYSTEM_CONTROL &&
    i_move.data[31] && !i_move.data[0]
    |=> o_answer.protection_fault && $stable(system_control[31:4]) &&
        $stable(system_control[2:0]))
    else $error("paging without protection accepted");
  paging_off_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R09
    !paging_flag |-> !o_flags.paging_on)
    else $error("paging reported while flag clear");
  cache_all_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R11
    !cache_off_flag && !no_wt_flag |-> o_flags.cache_all && o_flags.write_back_hits)
    else $error("full caching not reported");
  dir_flags_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R07
    !paging_flag || cache_off_flag
    |-> !o_flags.dir_cache_off && !o_flags.dir_write_through)
    else $error("directory cache flags reported while ignored");
  write_guard_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R13
    o_flags.write_guard == system_control[pcr_pkg::BIT_WRITE_GUARD])
    else $error("write guard output wrong");
  coproc_one_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R17
    system_control[4])
    else $error("coprocessor type bit cleared");
  task_sw_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R18
    i_task_switch |=> system_control[3])
    else $error("task switch lost");
  clear_sw_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R22
    i_clear_switched_instr && !i_task_switch &&
    !(i_move.valid && i_move.write && i_move.sel == pcr_pkg::SEL_SYSTEM_CONTROL)
    |=> !system_control[pcr_pkg::BIT_CONTEXT_SWITCHED])
    else $error("switched flag not cleared");
  switch_dna_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R19
    i_instr.valid && (i_instr.is_fpu || i_instr.is_vector) && !i_instr.is_wait &&
    !i_instr.is_exempt && switched_flag && !emulate_flag |-> o_device_unavailable_fault)
    else $error("switched fault missing");
  emu_vector_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R21
    i_instr.valid && i_instr.is_vector && !i_instr.is_fpu && !i_instr.is_wait &&
    emulate_flag |-> !o_device_unavailable_fault)
    else $error("switched flag not ignored under emulation");
  emu_fault_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R23
    i_instr.valid && i_instr.is_fpu && !i_instr.is_wait && emulate_flag
    |-> o_device_unavailable_fault)
    else $error("emulation fault missing");
  wait_mon_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R24
    i_instr.valid && i_instr.is_wait |-> o_device_unavailable_fault == (monitor_flag && switched_flag))
    else $error("wait fault wrong");
  wait_exec_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R20
    i_instr.valid && i_instr.is_wait && !monitor_flag |-> !o_device_unavailable_fault)
    else $error("wait faulted without monitor flag");
  dir_align_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R06
    o_flags.directory_base_pointer[11:0] == 12'h000)
    else $error("directory base misaligned");
  native_err_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R14
    i_fpu_error && native_flag |=> o_fpu_internal_fault)
    else $error("internal error report missing");
  ignore_err_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R15
    !native_flag && ign_sync |=> o_fpu_error_out_n)
    else $error("error pin asserted while ignored");
  legacy_err_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R16
    i_fpu_error && !native_flag && !ign_sync ##1 !native_flag && !ign_sync |-> !o_fpu_error_out_n)
    else $error("error pin not asserted");
  align_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R12
    o_flags.align_check_active |-> i_mode.current_privilege == 2'h3)
    else $error("alignment check outside user level");

  move_write_c: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    i_move.valid && i_move.write && !refuse);
  switch_fault_c: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    i_task_switch ##1 i_instr.valid && o_device_unavailable_fault);
  legacy_err_c: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    !o_fpu_error_out_n && o_fpu_stall);
  native_err_c: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    i_fpu_error && native_flag);
  emu_fault_c: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    i_instr.valid && emulate_flag && o_device_unavailable_fault);

endmodule

/* tb/tb.sv */
// Purpose: Self-checking bench for the control-register bank
// Assumes: Move answer is registered on the same edge that takes the request
// Notes: Random data and modes come from a fixed seed
`timescale 1ns/1ps
module tb;
  logic i_clk;
  logic i_rst_n;
  pcr_pkg::pcr_mode_t md;
  pcr_pkg::pcr_move_t mv;
  pcr_pkg::pcr_instr_t ins;
  pcr_pkg::pcr_answer_t ans;
  pcr_pkg::pcr_flags_t fl;
  logic [2:0] pls;
  logic ign_n, dna, ifault, fpu_error_out_n, stall;
  int failures, compares, seed, i;
  logic [63:0] d, q, x;

  pcr_bank dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_mode(md), .i_move(mv),
    .i_task_switch(pls[0]), .i_clear_switched_instr(pls[1]), .i_instr(ins),
    .i_fpu_error(pls[2]), .i_ignore_error_in_n(ign_n), .o_answer(ans),
    .o_device_unavailable_fault(dna), .o_fpu_internal_fault(ifault),
    .o_fpu_error_out_n(fpu_error_out_n), .o_fpu_stall(stall), .o_flags(fl));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    compares++;
    if (g !== e)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One move, answer checked the cycle after it is taken
  task automatic move(input logic w, input logic [3:0] s, input logic [63:0] v,
                      input logic f);
    @(posedge i_clk);
    mv <= '{1'b1, w, s, v};
    @(posedge i_clk);
    mv.valid <= 1'b0;
    #1;
    chk("done", 64'h1, ans.done);
    chk("fault", f, ans.protection_fault);
    chk("code", 64'h0, ans.fault_code);
    q = ans.data;
    if (f)
      chk("fault_data", 64'h0, q);
  endtask

  task automatic pulse(input int b);
    @(posedge i_clk);
    pls[b] <= 1'b1;
    @(posedge i_clk);
    pls <= 3'h0;
  endtask

  function automatic logic dna_exp(input int n);
    case (n[1:0])
      2'h0: return n[4] | n[2];
      2'h1: return n[3] & n[2];
      2'h2: return n[2] & ~n[4];
      default: return 1'b0;
    endcase
  endfunction

  task automatic wrap_up();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  initial
  begin
    #100us;
    failures++;
    wrap_up();
  end

  initial
  begin
    seed = 20774;
    i_rst_n = 1'b0;
    md = '{1'b1, 1'b1, 1'b0, 2'h0, 1'b0};
    mv = '0;
    ins = '0;
    pls = 3'h0;
    ign_n = 1'b1;
    repeat (12) @(posedge i_clk);
    i_rst_n <= 1'b1;
    move(1'b0, 4'h0, 64'h0, 1'b0);
    chk("sc_reset", pcr_pkg::SYSTEM_CONTROL_RESET, q);
    chk("cache_rst", 64'h0, fl.cache_all);
    move(1'b1, 4'h0, 64'h1_0000_0011, 1'b1);
    move(1'b1, 4'h4, 64'h8000_0000_0000_0000, 1'b1);
    move(1'b0, 4'h1, 64'h0, 1'b1);
    // Random full-width fault addresses, table base with 51:40 clear, no limit checks
    for (i = 0; i < 16; i++)
    begin
      d = {$random(seed), $random(seed)};
      move(1'b1, 4'h2, d, 1'b0);
      move(1'b0, 4'h2, 64'h0, 1'b0);
      chk("fla", d, q);
      d[51:40] = 12'h0;
      move(1'b1, 4'h3, d, 1'b0);
      move(1'b0, 4'h3, 64'h0, 1'b0);
      chk("tbase", d, q);
      chk("dbase", {d[51:12], 12'h000}, fl.directory_base_pointer);
    end
    @(posedge i_clk) md.long_mode <= 1'b0;
    move(1'b0, 4'h8, 64'h0, 1'b1);
    @(posedge i_clk) md.current_privilege <= 2'h3;
    move(1'b0, 4'h2, 64'h0, 1'b1);
    @(posedge i_clk) md.current_privilege <= 2'h1;
    move(1'b1, 4'h3, 64'h0, 1'b1);
    @(posedge i_clk) md <= '{1'b1, 1'b1, 1'b0, 2'h0, 1'b0};
    move(1'b1, 4'h8, 64'h5, 1'b0);
    chk("tpl", 64'h5, fl.task_priority_level);
    move(1'b1, 4'h0, 64'h8000_0000, 1'b1);
    chk("paging_off", 64'h0, fl.paging_on);
    move(1'b1, 4'h0, 64'h8000_0001, 1'b0);
    chk("paging", 64'h1, fl.paging_on);
    chk("cache_all", 64'h1, fl.cache_all);
    chk("wb", 64'h1, fl.write_back_hits);
    move(1'b1, 4'h3, 64'h18, 1'b0);
    chk("dir_nocache", 64'h1, fl.dir_cache_off);
    chk("dir_wthru", 64'h1, fl.dir_write_through);
    move(1'b1, 4'h0, 64'h1_0001, 1'b0);
    chk("wg", 64'h1, fl.write_guard);
    chk("paging_clr", 64'h0, fl.paging_on);
    // Alignment gate against random execution contexts
    move(1'b1, 4'h0, 64'h4_0001, 1'b0);
    for (i = 0; i < 32; i++)
    begin
      x = $random(seed);
      @(posedge i_clk);
      md <= x[5:0];
      #1;
      chk("align", md.align_check_flag & md.current_privilege == 2'h3 &
          (md.protected_mode | md.v86_mode), fl.align_check_active);
    end
    @(posedge i_clk) md <= '{1'b1, 1'b1, 1'b0, 2'h0, 1'b0};
    // Emulation, monitor and switched flags against each instruction kind
    for (i = 0; i < 32; i++)
    begin
      move(1'b1, 4'h0, {60'h0, i[2], i[4], i[3], 1'b1}, 1'b0);
      @(posedge i_clk);
      ins <= '{1'b1, i[1:0] == 2'h0, i[1], i[1:0] == 2'h1, i[1:0] == 2'h3};
      #1;
      chk("dna", dna_exp(i), dna);
    end
    @(posedge i_clk) ins <= '0;
    move(1'b1, 4'h0, 64'h1, 1'b0);
    pulse(0);
    move(1'b0, 4'h0, 64'h0, 1'b0);
    chk("switched_set", 64'h19, q);
    pulse(1);
    move(1'b0, 4'h0, 64'h0, 1'b0);
    chk("switched_clr", 64'h11, q);
    move(1'b1, 4'h0, 64'h21, 1'b0);
    pulse(2);
    #1;
    chk("int_fault", 64'h1, ifault);
    chk("pin_native", 64'h1, fpu_error_out_n);
    move(1'b1, 4'h0, 64'h1, 1'b0);
    pulse(2);
    #1;
    chk("pin", 64'h0, fpu_error_out_n);
    @(posedge i_clk);
    ins <= '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
    #1;
    chk("stall", 64'h1, stall);
    @(posedge i_clk);
    ins <= '0;
    ign_n <= 1'b0;
    repeat (4) @(posedge i_clk);
    #1;
    chk("pin_ign", 64'h1, fpu_error_out_n);
    pulse(2);
    repeat (2) @(posedge i_clk);
    #1;
    chk("pin_drop", 64'h1, fpu_error_out_n);
    wrap_up();
  end
endmodule
